/* src/gpport_top.sv */
`timescale 1ns/1ps
`include "gpport_params.svh"
// GPIO ports 3..8 with Wishbone classic register slave
module gpport_top (
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   input  wire logic         ce_i,
   input  wire logic [31:0]  wb_adr_i,
   input  wire logic [31:0]  wb_dat_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic         wb_we_i,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   output logic      [31:0]  wb_dat_o,
   output logic              wb_ack_o,
   input  wire logic [47:0]  pad_in_i,
   output logic      [47:0]  pad_out_o,
   output logic      [47:0]  pad_oe_o,
   output logic      [47:0]  pad_pu_o,
   output logic      [47:0]  pad_pd_o
);
   import gpport_pkg::*;
   localparam int NP = `GPP_NUM_PORTS;
   // Port order: 3,4,5,6,7,8; widths and pull-down capability
   localparam int WID [NP] = '{7, 8, 8, 7, 8, 8};
   localparam bit PDN [NP] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
   localparam int POLB [NP] = '{0, `GPP_POL_BIT_P4, `GPP_POL_BIT_P5, 0,
                                `GPP_POL_BIT_P7, 0};

   logic [7:0] out_r  [NP];
   logic [7:0] out_nxt[NP];
   logic [7:0] dir_r  [NP];
   logic [7:0] dir_nxt[NP];
   logic [7:0] pull_r [NP];
   logic [7:0] pull_nxt[NP];
   logic [7:0] level  [NP];
   logic [`GPP_POL_WIDTH-1:0] pull_polarity_select_r;
   logic [`GPP_POL_WIDTH-1:0] pol_nxt;
   logic [31:0]  rdat_r;
   logic [31:0]  rdat_nxt;
   gpport_bus_state_type st_r;
   gpport_bus_state_type st_nxt;
   gpport_wb_req_type req;
   logic [7:0] ofs;
   logic       hit;

   assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i,
                  we: wb_we_i, cyc: wb_cyc_i, stb: wb_stb_i};
   assign ofs = req.adr[7:0];
   assign hit = req.cyc & req.stb & (st_r == GPP_IDLE) & ce_i;

   // Elaboration checks on the port table
   if (NP * 8 != 48) begin : g_bad_np
      $error("gpport port table does not fill the pad bus");
   end
   for (genvar p = 0; p < NP; p++) begin : g_chk
      // Each port fits one byte lane of its registers
      if (WID[p] < 1 || WID[p] > 8) begin : g_bad_wid
         $error("gpport port width must be 1..8");
      end
      // A pull-down capable port needs a polarity bit inside the select field
      if (PDN[p] && POLB[p] >= `GPP_POL_WIDTH) begin : g_bad_pol
         $error("gpport polarity bit outside the select field");
      end
   end

   // Register match per port, and the write strobe
   logic [NP-1:0] at_out;
   logic [NP-1:0] at_dir;
   logic [NP-1:0] at_pull;
   logic [NP-1:0] at_in;
   logic          at_pol;
   logic          wr;

   // Address match for each register of each port
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         at_out[p]  = (ofs == 8'(`GPP_OFS_OUT_BASE + p * `GPP_OFS_STRIDE));
         at_dir[p]  = (ofs == 8'(`GPP_OFS_DIR_BASE + p * `GPP_OFS_STRIDE));
         at_pull[p] = (ofs == 8'(`GPP_OFS_PULL_BASE + p * `GPP_OFS_STRIDE));
         at_in[p]   = (ofs == 8'(`GPP_OFS_IN_BASE + p * `GPP_OFS_STRIDE));
      end
      at_pol = (ofs == `GPP_OFS_POLSEL);
   end

   // Only lane 0 carries the 8-bit registers
   assign wr = hit & req.we & req.sel[0];

   // Port register next values; bits above the port width stay 0
   always_comb begin
      logic [7:0] m;
      m = 8'h00;
      for (int p = 0; p < NP; p++) begin
         m = 8'((1 << WID[p]) - 1);
         out_nxt[p]  = out_r[p];
         dir_nxt[p]  = dir_r[p];
         pull_nxt[p] = pull_r[p];
         if (wr && at_out[p]) begin
            out_nxt[p] = req.dat[7:0] & m;
         end
         if (wr && at_dir[p]) begin
            dir_nxt[p] = req.dat[7:0] & m;
         end
         if (wr && at_pull[p]) begin
            pull_nxt[p] = req.dat[7:0] & m;
         end
      end
   end

   // Port registers: reset leaves every pin an input with no pulls
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int p = 0; p < NP; p++) begin
            out_r[p]  <= `GPP_RST_OUT;
            dir_r[p]  <= `GPP_RST_DIR;
            pull_r[p] <= `GPP_RST_PULL;
         end
      end else begin
         for (int p = 0; p < NP; p++) begin
            out_r[p]  <= out_nxt[p];
            dir_r[p]  <= dir_nxt[p];
            pull_r[p] <= pull_nxt[p];
         end
      end
   end

   // Polarity select next value: one up/down choice per capable port
   always_comb begin
      pol_nxt = pull_polarity_select_r;
      if (wr && at_pol) begin
         pol_nxt = req.dat[`GPP_POL_WIDTH-1:0];
      end
   end

   // Polarity register: reset selects pull-up for ports 4, 5, 7
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pull_polarity_select_r <= `GPP_RST_POL;
      end else begin
         pull_polarity_select_r <= pol_nxt;
      end
   end

   // Read data, captured as a request is taken; unmapped reads 0
   always_comb begin
      rdat_nxt = rdat_r;
      if (hit) begin
         rdat_nxt = 32'h0000_0000;
         for (int p = 0; p < NP; p++) begin
            if (at_out[p]) begin
               rdat_nxt = {24'h00_0000, out_r[p]};
            end
            if (at_dir[p]) begin
               rdat_nxt = {24'h00_0000, dir_r[p]};
            end
            if (at_pull[p]) begin
               rdat_nxt = {24'h00_0000, pull_r[p]};
            end
            if (at_in[p]) begin
               rdat_nxt = {24'h00_0000, level[p]};
            end
         end
         if (at_pol) begin
            rdat_nxt = {29'h0000_0000, pull_polarity_select_r};
         end
      end
   end

   // Read data register, held until the next request is taken
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdat_r <= 32'h0000_0000;
      end else begin
         rdat_r <= rdat_nxt;
      end
   end

   // Bus handshake next state: ack one cycle after the take
   always_comb begin
      case (st_r)
         GPP_IDLE: st_nxt = hit ? GPP_ACK : GPP_IDLE;
         GPP_ACK:  st_nxt = ce_i ? GPP_IDLE : GPP_ACK;
         default:  st_nxt = GPP_IDLE;
      endcase
   end

   // Bus handshake state register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r <= GPP_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Ack straight from the state; read data from its flop
   assign wb_ack_o = (st_r == GPP_ACK);
   assign wb_dat_o = rdat_r;

   // One pad controller per port
   for (genvar p = 0; p < NP; p++) begin : g_port
      gpport_pad_type pad;
      gpport_bit_ctrl #(.WIDTH(WID[p]), .HAS_PDOWN(PDN[p])) u_ctrl (
         .clk_i       (clk_i),
         .rstn_i      (rstn_i),
         .ce_i        (ce_i),
         .out_latch_i (out_r[p][WID[p]-1:0]),
         .dir_i       (dir_r[p][WID[p]-1:0]),
         .pull_en_i   (pull_r[p][WID[p]-1:0]),
         .pull_down_i (pull_polarity_select_r[POLB[p]]),
         .pad_i       (pad_in_i[p*8 +: WID[p]]),
         .pad_o       (pad),
         .level_o     (level[p][WID[p]-1:0])
      );
      if (WID[p] < 8) begin : g_pad
         assign level[p][7:WID[p]] = '0;
      end
      assign pad_out_o[p*8 +: 8] = pad.out;
      assign pad_oe_o[p*8 +: 8]  = pad.oe;
      assign pad_pu_o[p*8 +: 8]  = pad.pu;
      assign pad_pd_o[p*8 +: 8]  = pad.pd;
   end
endmodule

/* src/gpport_params.svh */
// Behaviour
// - Each port bit has its own direction bit, input or output.
// - Ports 3, 6, 8 have one independent pull-up enable bit per pin.
// - Ports 4, 5, 7 have per-pin pull enables acting as up or down.
// - A shared selection register holds one up/down selector for each of ports 4, 5, 7.
// - Within one port, enabled pulls are all the same type, never mixed.
// - Reset clears directions to input and pull enables to disabled.
`ifndef GPPORT_PARAMS_SVH
`define GPPORT_PARAMS_SVH
`define GPP_NUM_PORTS      6
// Register offsets (byte addresses)
`define GPP_OFS_OUT_BASE   8'h00
`define GPP_OFS_DIR_BASE   8'h18
`define GPP_OFS_PULL_BASE  8'h30
`define GPP_OFS_IN_BASE    8'h48
`define GPP_OFS_POLSEL     8'h60
`define GPP_OFS_STRIDE     8'h04
// Pull polarity select field positions: ports 4, 5, 7
`define GPP_POL_BIT_P4     0
`define GPP_POL_BIT_P5     1
`define GPP_POL_BIT_P7     2
`define GPP_POL_WIDTH      3
// Reset values
`define GPP_RST_DIR        8'h00
`define GPP_RST_PULL       8'h00
`define GPP_RST_OUT        8'h00
`define GPP_RST_POL        3'h0
`endif

/* src/gpport_pkg.sv */
package gpport_pkg;
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pu;
      logic [7:0] pd;
   } gpport_pad_type;
   typedef struct packed {
      logic [31:0] adr;
      logic [31:0] dat;
      logic [3:0]  sel;
      logic        we;
      logic        cyc;
      logic        stb;
   } gpport_wb_req_type;
   typedef enum logic [0:0] {
      GPP_IDLE,
      GPP_ACK
   } gpport_bus_state_type;
endpackage

/* src/gpport_bit_ctrl.sv */
`timescale 1ns/1ps
// One port: pad control and input sync
module gpport_bit_ctrl #(
   parameter int WIDTH     = 8,
   parameter bit HAS_PDOWN = 1'b0
) (
   input  wire logic              clk_i,
   input  wire logic              rstn_i,
   input  wire logic              ce_i,
   input  wire logic [WIDTH-1:0]  out_latch_i,
   input  wire logic [WIDTH-1:0]  dir_i,
   input  wire logic [WIDTH-1:0]  pull_en_i,
   input  wire logic              pull_down_i,
   input  wire logic [WIDTH-1:0]  pad_i,
   output gpport_pkg::gpport_pad_type pad_o,
   output logic      [WIDTH-1:0]  level_o
);
   import gpport_pkg::*;
   logic [WIDTH-1:0] sync1_r;
   logic [WIDTH-1:0] sync1_nxt;
   logic [WIDTH-1:0] level_r;
   logic [WIDTH-1:0] level_nxt;

   initial begin
      if (WIDTH < 1 || WIDTH > 8) $error("gpport width must be 1..8");
   end

   // Input synchroniser next values
   always_comb begin
      sync1_nxt = ce_i ? pad_i : sync1_r;
      level_nxt = ce_i ? sync1_r : level_r;
   end

   // Input synchroniser registers
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_r <= '0;
         level_r <= '0;
      end else begin
         sync1_r <= sync1_nxt;
         level_r <= level_nxt;
      end
   end
   assign level_o = level_r;

   // Per-bit pad drive and pull steering
   always_comb begin
      pad_o = '0;
      for (int i = 0; i < WIDTH; i++) begin
         pad_o.oe[i]  = dir_i[i];
         pad_o.out[i] = dir_i[i] & out_latch_i[i];
         // One polarity per port, so pulls never mix
         pad_o.pu[i]  = pull_en_i[i] & ~(HAS_PDOWN & pull_down_i);
         pad_o.pd[i]  = pull_en_i[i] & HAS_PDOWN & pull_down_i;
      end
   end
endmodule

/* tb/gpport_props.sv */
`timescale 1ns/1ps
// Port checks on the pad controls and register writes
module gpport_props (
   input wire logic        clk_i,
   input wire logic        rstn_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic        wb_we_i,
   input wire logic        wb_ack_o,
   input wire logic [47:0] pad_out_o,
   input wire logic [47:0] pad_oe_o,
   input wire logic [47:0] pad_pu_o,
   input wire logic [47:0] pad_pd_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   logic [47:0] pl;
   logic        wt;
   // Any pull connected, and a write being answered
   assign pl = pad_pu_o | pad_pd_o;
   assign wt = wb_ack_o & wb_we_i & wb_sel_i[0];
   a_out_gated: assert property ((pad_out_o & ~pad_oe_o) == 48'h0)
      else $error("pin driven while input");
   a_narrow_port: assert property ({pad_oe_o[31], pad_oe_o[7], pl[31],
      pl[7]} == 4'h0) else $error("missing bit of narrow port active");
   a_pu_only: assert property ({pad_pd_o[47:40], pad_pd_o[31:24],
      pad_pd_o[7:0]} == 24'h0) else $error("pull-down on pull-up port");
   a_no_mixing: assert property (!(|pad_pu_o[15:8] && |pad_pd_o[15:8])
      && !(|pad_pu_o[23:16] && |pad_pd_o[23:16])
      && !(|pad_pu_o[39:32] && |pad_pd_o[39:32])) else $error("mixed pulls");
   a_dir_write: assert property (wt && wb_adr_i == 32'h18 |->
      pad_oe_o[6:0] == wb_dat_i[6:0]) else $error("direction not applied");
   a_pull_write: assert property (wt && wb_adr_i == 32'h34 |->
      pl[15:8] == wb_dat_i[7:0]) else $error("pull enable not applied");
   a_pol_down: assert property (wt && wb_adr_i == 32'h60 && wb_dat_i[0]
      |-> pad_pu_o[15:8] == 8'h0) else $error("pull-up left on");
   a_pads_hold: assert property (!wb_ack_o |-> $stable(pad_oe_o))
      else $error("direction moved without a write");
   c_pol: cover property (wt && wb_adr_i == 32'h60);
   c_down: cover property (|pad_pd_o);
   c_drive: cover property (|pad_oe_o);
endmodule

/* tb/gpport_pins.sv */
`timescale 1ns/1ps
// Pin side: own driver, outside drive, pulls, floating lines
module gpport_pins (
   input  wire logic        clk_i,
   input  wire logic [47:0] out_i,
   input  wire logic [47:0] oe_i,
   input  wire logic [47:0] pu_i,
   input  wire logic [47:0] pd_i,
   input  wire logic [47:0] ext_i,
   input  wire logic [47:0] ext_en_i,
   output logic      [47:0] pin_o
);
   logic [47:0] flt_r = 48'h5555_5555_5555;
   // Unpulled, undriven lines wander every cycle
   always @(posedge clk_i) flt_r <= ~flt_r;
   // Each bit resolved on its own
   always_comb begin
      for (int b = 0; b < 48; b++) begin
         if (oe_i[b]) pin_o[b] = out_i[b];
         else if (ext_en_i[b]) pin_o[b] = ext_i[b];
         else if (pu_i[b] | pd_i[b]) pin_o[b] = pu_i[b];
         else pin_o[b] = flt_r[b];
      end
   end
endmodule

/* tb/tb_gpport_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_gpport_top;
   logic        clk_i = 0;
   logic        rstn_i = 0;
   logic [31:0] adr = 0, dat = 0, q, rdat;
   logic        we = 0, cyc = 0, ack;
   logic        ce = 1'h1;
   logic [3:0]  sel = 4'h1, lane = 4'h1;
   logic [47:0] pin, po, oe, pu, pd, ext = 0, ext_en = 0;
   logic [7:0]  m;
   int          errors = 0;
   int          n_compared = 0;
   always #5 clk_i = ~clk_i;
   gpport_top u_gpport_top (.clk_i, .rstn_i, .ce_i(ce), .wb_adr_i(adr),
      .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack), .pad_in_i(pin),
      .pad_out_o(po), .pad_oe_o(oe), .pad_pu_o(pu), .pad_pd_o(pd));
   gpport_pins u_gpport_pins (.clk_i, .out_i(po), .oe_i(oe), .pu_i(pu),
      .pd_i(pd), .ext_i(ext), .ext_en_i(ext_en), .pin_o(pin));
   // One classic cycle; read data lands in q
   task automatic bus(input logic [31:0] a, d, input logic w);
      @(posedge clk_i);
      cyc <= 1'h1;
      adr <= a;
      dat <= d;
      sel <= lane;
      we <= w;
      do @(posedge clk_i); while (ack !== 1'h1);
      q = rdat;
      cyc <= 1'h0;
   endtask
   task automatic rd(input logic [31:0] a, e, input string n);
      bus(a, 32'h0, 1'h0);
      `CHK(n, e, q)
   endtask
   task automatic test_done;
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      rstn_i <= 1'h1;
      `CHK("pads", 192'h0, {po, oe, pu, pd})
      for (int p = 0; p < 6; p++) begin
         rd(32'h18 + 4 * p, 32'h0, "dir");
         rd(32'h30 + 4 * p, 32'h0, "pull");
      end
      $display("reset test done");
      for (int p = 0; p < 6; p++) begin
         m = (p == 0 || p == 3) ? 8'h7F : 8'hFF;
         bus(32'h30 + 4 * p, 32'hDA, 1'h1);
         `CHK("pull up", 8'hDA & m, pu[p*8+:8])
         rd(32'h30 + 4 * p, 8'hDA & m, "pull");
      end
      for (int s = 0; s < 8; s++) begin
         bus(32'h60, s, 1'h1);
         `CHK("down", {{8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & 24'hDA_DADA,
            {pd[39:32], pd[23:8]})
         `CHK("up", ~{{8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & 24'hDA_DADA,
            {pu[39:32], pu[23:8]})
         rd(32'h60, s, "polarity");
      end
      $display("pull test done");
      ext <= 48'h9C36_A5C3_5A69;
      ext_en <= 48'hFFFF_FFFF_FFFF;
      for (int p = 0; p < 6; p++) begin
         m = (p == 0 || p == 3) ? 8'h7F : 8'hFF;
         bus(4 * p, 32'h3C, 1'h1);
         repeat (3) @(posedge clk_i);
         rd(32'h48 + 4 * p, ext[p*8+:8] & m, "pin in");
         bus(32'h18 + 4 * p, 32'hF0, 1'h1);
         `CHK("drive", {8'hF0 & m, 8'h30 & m},
            {oe[p*8+:8], po[p*8+:8]})
         repeat (3) @(posedge clk_i);
         rd(32'h48 + 4 * p, (8'h30 | ext[p*8+:8] & 8'h0F) & m, "mix");
         rd(32'h18 + 4 * p, 8'hF0 & m, "dir");
      end
      $display("direction test done");
      bus(32'h70, 32'hFF, 1'h1);
      rd(32'h70, 32'h0, "unmapped");
      $display("unmapped test done");
      // Clock enable low: the request waits and nothing moves
      ce <= 1'h0;
      @(posedge clk_i);
      cyc <= 1'h1;
      adr <= 32'h60;
      dat <= 32'h2;
      we <= 1'h1;
      repeat (3) @(posedge clk_i);
      `CHK("frozen ack", 1'h0, ack)
      `CHK("frozen pull", 8'hDA, pd[15:8])
      ce <= 1'h1;
      do @(posedge clk_i); while (ack !== 1'h1);
      cyc <= 1'h0;
      `CHK("released pull", 8'hDA, pu[15:8])
      rd(32'h60, 32'h2, "polarity");
      $display("clock enable test done");
      // A write without lane 0 leaves the register alone
      lane = 4'hE;
      bus(32'h34, 32'h0, 1'h1);
      lane = 4'h1;
      rd(32'h34, 32'hDA, "lane ignored");
      $display("lane test done");
      rstn_i <= 1'h0;
      @(posedge clk_i);
      `CHK("pads", 192'h0, {po, oe, pu, pd})
      rstn_i <= 1'h1;
      rd(32'h60, 32'h0, "polarity");
      $display("second reset test done");
      test_done;
   end
   // Watchdog well past the expected run
   initial begin
      #20_000;
      errors++;
      test_done;
   end
endmodule
bind gpport_top gpport_props u_gpport_props (.clk_i(clk_i), .rstn_i(rstn_i),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
   .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .pad_out_o(pad_out_o),
   .pad_oe_o(pad_oe_o), .pad_pu_o(pad_pu_o), .pad_pd_o(pad_pd_o));
